// ---- src/evt_stat.sv ----
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// Purpose: fifo threshold registers and overflow/underflow event flags
// Assumes: fifo levels, pushes and pops come from the controller core
// Notes:   masks, enable and abort cause sit at addresses of our own
module evt_stat #(
  parameter int DEPTH = evt_stat_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst,
  // register port
  input  wire logic [evt_stat_pkg::ADDR_W-1:0]  addr,
  input  wire logic [evt_stat_pkg::DATA_W-1:0]  wdata,
  input  wire logic                             wr,
  input  wire logic                             rd,
  output logic      [evt_stat_pkg::DATA_W-1:0]  rdata_q,
  // controller core
  input  wire logic [evt_stat_pkg::LVL_W-1:0]   rx_level,
  input  wire logic [evt_stat_pkg::LVL_W-1:0]   tx_level,
  input  wire logic                             cmd_write,
  input  wire logic                             data_read,
  input  wire logic                             rx_byte_in,
  input  wire logic                             engines_idle,
  input  wire logic                             abort_event,
  input  wire logic [evt_stat_pkg::DATA_W-1:0]  abort_cause_in,
  // outputs to core
  output logic                                  enable_q,
  output logic                                  internal_enable_state_q,
  output logic                                  rx_flush_q,
  output logic                                  rx_ack_q,
  output logic                                  rx_store_q,
  output logic      [evt_stat_pkg::FLAG_N-1:0]  masked_status_q
);
  import evt_stat_pkg::*;

  logic [TL_W-1:0]   rx_thr_q;
  logic [TL_W-1:0]   tx_thr_q;
  logic [FLAG_N-1:0] mask_q;
  logic [DATA_W-1:0] abort_cause_q;
  logic              rxu_q;
  logic              rxo_q;
  logic              txo_q;
  logic              rx_full;
  logic              tx_empty;

  // depth clamp: anything past depth minus one stores depth minus one (n+1 entries)
  function automatic logic [TL_W-1:0] clamp_thr(input logic [DATA_W-1:0] v);
    if (v > DATA_W'(DEPTH - 1)) begin
      return TL_W'(DEPTH - 1);
    end
    return v[TL_W-1:0];
  endfunction

  // address decode
  wire sel_rx_threshold  = (addr == ADDR_RX_THRESHOLD);
  wire sel_tx_tl  = (addr == ADDR_TX_TL);
  wire sel_mask   = (addr == ADDR_MASK);
  wire sel_enable = (addr == ADDR_ENABLE);
  wire clr_all    = rd && (addr == ADDR_CLR_ALL);
  wire clr_rxu    = rd && (addr == ADDR_CLR_RXU) || clr_all;
  wire clr_rxo    = rd && (addr == ADDR_CLR_RXO) || clr_all;
  wire clr_txo    = rd && (addr == ADDR_CLR_TXO) || clr_all;
  wire full_lvl   = (rx_level >= LVL_W'(DEPTH));
  wire tx_full    = (tx_level >= LVL_W'(DEPTH));

  // event sources
  wire ev_txo = cmd_write && tx_full;
  wire ev_rxo = rx_byte_in && full_lvl;
  wire ev_rxu = data_read && (rx_level == LVL_W'(0));
  // disabled controller: flags hold until the engines go idle
  wire drop   = !internal_enable_state_q;

  // sticky flags; set beats a same-cycle clear
  wire rxu_d = ev_rxu || (rxu_q && !clr_rxu && !drop);
  wire rxo_d = ev_rxo || (rxo_q && !clr_rxo && !drop);
  wire txo_d = ev_txo || (txo_q && !clr_txo && !drop);

  wire [FLAG_N-1:0] raw = {7'h00, tx_empty, txo_q, rx_full, rxo_q, rxu_q};

  // abort cause: bit 9 survives a clear-all
  wire [DATA_W-1:0] abrt_keep = DATA_W'(1) << ABRT_KEEP_BIT;
  wire [DATA_W-1:0] abrt_d    = abort_event ? abort_cause_in :
                                clr_all ? (abort_cause_q & abrt_keep) : abort_cause_q;

  // read mux, reserved bits zero
  wire [DATA_W-1:0] rmux =
      (addr == ADDR_STAT)   ? DATA_W'(raw) :
      (addr == ADDR_MSTAT)  ? DATA_W'(raw & mask_q) :
      sel_mask              ? DATA_W'(mask_q) :
      sel_rx_threshold             ? DATA_W'(rx_thr_q) :
      sel_tx_tl             ? DATA_W'(tx_thr_q) :
      sel_enable            ? DATA_W'(enable_q) :
      (addr == ADDR_ABRT)   ? abort_cause_q :
      DATA_W'(0);

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_thr_q <= TL_RST;
      tx_thr_q <= TL_RST;
      mask_q   <= MASK_RST;
      enable_q <= 1'b0;
    end else if (wr) begin
      if (sel_rx_threshold) begin
        rx_thr_q <= clamp_thr(wdata);
      end else if (sel_tx_tl) begin
        tx_thr_q <= clamp_thr(wdata);
      end else if (sel_mask) begin
        mask_q <= wdata[FLAG_N-1:0];
      end else if (sel_enable) begin
        enable_q <= wdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      internal_enable_state_q <= 1'b0;
      rx_flush_q              <= 1'b1;
      rxu_q                   <= 1'b0;
      rxo_q                   <= 1'b0;
      txo_q                   <= 1'b0;
      abort_cause_q           <= '0;
      rdata_q                 <= '0;
      rx_ack_q                <= 1'b0;
      rx_store_q              <= 1'b0;
      masked_status_q         <= '0;
    end else begin
      // enable state falls only once engines are idle
      if (enable_q) begin
        internal_enable_state_q <= 1'b1;
      end else if (engines_idle) begin
        internal_enable_state_q <= 1'b0;
      end
      rx_flush_q      <= !(wr && sel_enable ? wdata[0] : enable_q);
      rxu_q           <= rxu_d;
      rxo_q           <= rxo_d;
      txo_q           <= txo_d;
      abort_cause_q   <= abrt_d;
      rdata_q         <= rd ? rmux : '0;
      rx_ack_q        <= rx_byte_in;
      rx_store_q      <= rx_byte_in && !full_lvl;
      masked_status_q <= raw & mask_q;
    end
  end

  // rx flag forced low while flushed, immediately after enable write
  level_flags u_lvl (
    .clk        (clk),
    .rst        (rst),
    .rx_level   (rx_level),
    .tx_level   (tx_level),
    .rx_thr     (rx_thr_q),
    .tx_thr     (tx_thr_q),
    .rx_hold    (!enable_q || (wr && sel_enable && !wdata[0])),
    .tx_hold    (!enable_q && !internal_enable_state_q),
    .rx_full_q  (rx_full),
    .tx_empty_q (tx_empty)
  );

  // checks
  property p_txo_set;
    @(posedge clk) disable iff (rst) (cmd_write && tx_full) |=> txo_q;
  endproperty
  a_txo_set: assert property (p_txo_set) else $error("tx overflow not set");

  property p_rxo_set;
    @(posedge clk) disable iff (rst)
      (rx_byte_in && full_lvl) |=> (rxo_q && rx_ack_q && !rx_store_q);
  endproperty
  a_rxo_set: assert property (p_rxo_set) else $error("rx overflow handling wrong");

  property p_rxu_set;
    @(posedge clk) disable iff (rst) (data_read && rx_level == LVL_W'(0)) |=> rxu_q;
  endproperty
  a_rxu_set: assert property (p_rxu_set) else $error("rx underflow not set");

  property p_rxu_clr;
    @(posedge clk) disable iff (rst)
      (rd && addr == ADDR_CLR_RXU && !ev_rxu) |=> !rxu_q;
  endproperty
  a_rxu_clr: assert property (p_rxu_clr) else $error("rx underflow not cleared");

  property p_rxo_clr;
    @(posedge clk) disable iff (rst)
      (rd && addr == ADDR_CLR_RXO && !ev_rxo) |=> !rxo_q;
  endproperty
  a_rxo_clr: assert property (p_rxo_clr) else $error("rx overflow not cleared");

  sequence s_disable_idle;
    !internal_enable_state_q ##0 !ev_txo;
  endsequence
  property p_drop;
    @(posedge clk) disable iff (rst) s_disable_idle |=> !txo_q;
  endproperty
  a_drop: assert property (p_drop) else $error("flag held past enable drop");

  property p_rxf_clr;
    @(posedge clk) disable iff (rst) (wr && sel_enable && !wdata[0]) |=> !rx_full;
  endproperty
  a_rxf_clr: assert property (p_rxf_clr) else $error("rx level flag not cleared");

  property p_thr_clamp;
    @(posedge clk) disable iff (rst)
      (wr && sel_rx_threshold && wdata > DATA_W'(DEPTH - 1)) |=> rx_thr_q == TL_W'(DEPTH - 1);
  endproperty
  a_thr_clamp: assert property (p_thr_clamp) else $error("threshold not clamped");

  property p_mask;
    @(posedge clk) disable iff (rst) ##1 (masked_status_q == ($past(raw) & $past(mask_q)));
  endproperty
  a_mask: assert property (p_mask) else $error("masked status wrong");

  property p_clr_all;
    @(posedge clk) disable iff (rst)
      (clr_all && !abort_event) |=> (abort_cause_q & ~abrt_keep) == '0;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("abort cause not cleared");

  // helpers for the checks; thresholds widened to the level width
  wire [LVL_W-1:0] rx_thr_lvl = LVL_W'(rx_thr_q);
  wire [LVL_W-1:0] tx_thr_lvl = LVL_W'(tx_thr_q);
  wire             en_off_wr  = wr && sel_enable && !wdata[0];
  wire             clr_rd     = rd && (addr == ADDR_CLR_ALL || addr == ADDR_CLR_RXU ||
                                       addr == ADDR_CLR_RXO || addr == ADDR_CLR_TXO);

  // disabled while the engines still run: flags must hold
  sequence s_off_busy;
    !enable_q && internal_enable_state_q && !engines_idle;
  endsequence

  property p_rxf_set;
    @(posedge clk) disable iff (rst)
      (enable_q && !en_off_wr && rx_level > rx_thr_lvl) |=> rx_full;
  endproperty
  a_rxf_set: assert property (p_rxf_set) else $error("rx level flag not set");

  property p_rxf_low;
    @(posedge clk) disable iff (rst) (rx_level <= rx_thr_lvl) |=> !rx_full;
  endproperty
  a_rxf_low: assert property (p_rxf_low) else $error("rx level flag early");

  property p_rxf_off;
    @(posedge clk) disable iff (rst) !enable_q |=> !rx_full;
  endproperty
  a_rxf_off: assert property (p_rxf_off) else $error("rx level flag while off");

  property p_flush;
    @(posedge clk) disable iff (rst) (!enable_q && !(wr && sel_enable)) |=> rx_flush_q;
  endproperty
  a_flush: assert property (p_flush) else $error("rx fifo not held");

  property p_txe_set;
    @(posedge clk) disable iff (rst)
      ((enable_q || internal_enable_state_q) && tx_level <= tx_thr_lvl) |=> tx_empty;
  endproperty
  a_txe_set: assert property (p_txe_set) else $error("tx level flag not set");

  property p_txe_low;
    @(posedge clk) disable iff (rst) (tx_level > tx_thr_lvl) |=> !tx_empty;
  endproperty
  a_txe_low: assert property (p_txe_low) else $error("tx level flag late");

  property p_txe_off;
    @(posedge clk) disable iff (rst) (!enable_q && !internal_enable_state_q) |=> !tx_empty;
  endproperty
  a_txe_off: assert property (p_txe_off) else $error("tx level flag while idle");

  property p_ien_rise;
    @(posedge clk) disable iff (rst) enable_q |=> internal_enable_state_q;
  endproperty
  a_ien_rise: assert property (p_ien_rise) else $error("enable state not set");

  property p_ien_hold;
    @(posedge clk) disable iff (rst) s_off_busy |=> internal_enable_state_q;
  endproperty
  a_ien_hold: assert property (p_ien_hold) else $error("enable state fell early");

  property p_ien_fall;
    @(posedge clk) disable iff (rst) (!enable_q && engines_idle) |=> !internal_enable_state_q;
  endproperty
  a_ien_fall: assert property (p_ien_fall) else $error("enable state stuck");

  property p_rxu_hold;
    @(posedge clk) disable iff (rst) (s_off_busy ##0 (rxu_q && !clr_rxu)) |=> rxu_q;
  endproperty
  a_rxu_hold: assert property (p_rxu_hold) else $error("rx underflow lost");

  property p_rxo_hold;
    @(posedge clk) disable iff (rst) (s_off_busy ##0 (rxo_q && !clr_rxo)) |=> rxo_q;
  endproperty
  a_rxo_hold: assert property (p_rxo_hold) else $error("rx overflow lost");

  property p_txo_hold;
    @(posedge clk) disable iff (rst) (s_off_busy ##0 (txo_q && !clr_txo)) |=> txo_q;
  endproperty
  a_txo_hold: assert property (p_txo_hold) else $error("tx overflow lost");

  property p_drop_rx;
    @(posedge clk) disable iff (rst)
      (!internal_enable_state_q && !ev_rxu && !ev_rxo) |=> (!rxu_q && !rxo_q);
  endproperty
  a_drop_rx: assert property (p_drop_rx) else $error("rx flags held past enable drop");

  property p_clr_flags;
    @(posedge clk) disable iff (rst)
      (clr_all && !ev_rxu && !ev_rxo && !ev_txo) |=> !(rxu_q || rxo_q || txo_q);
  endproperty
  a_clr_flags: assert property (p_clr_flags) else $error("clear-all left a flag");

  property p_keep9;
    @(posedge clk) disable iff (rst)
      (clr_all && !abort_event) |=>
        abort_cause_q[ABRT_KEEP_BIT] == $past(abort_cause_q[ABRT_KEEP_BIT]);
  endproperty
  a_keep9: assert property (p_keep9) else $error("abort keep bit changed");

  property p_ack;
    @(posedge clk) disable iff (rst) rx_byte_in |=> rx_ack_q;
  endproperty
  a_ack: assert property (p_ack) else $error("byte not acknowledged");

  property p_tx_clamp;
    @(posedge clk) disable iff (rst)
      (wr && sel_tx_tl && wdata > DATA_W'(DEPTH - 1)) |=> tx_thr_q == TL_W'(DEPTH - 1);
  endproperty
  a_tx_clamp: assert property (p_tx_clamp) else $error("tx threshold not clamped");

  property p_rx_store;
    @(posedge clk) disable iff (rst)
      (wr && sel_rx_threshold && wdata <= DATA_W'(DEPTH - 1)) |=>
        rx_thr_q == $past(wdata[TL_W-1:0]);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("rx threshold not stored");

  property p_tx_store;
    @(posedge clk) disable iff (rst)
      (wr && sel_tx_tl && wdata <= DATA_W'(DEPTH - 1)) |=>
        tx_thr_q == $past(wdata[TL_W-1:0]);
  endproperty
  a_tx_store: assert property (p_tx_store) else $error("tx threshold not stored");

  property p_rd_thr;
    @(posedge clk) disable iff (rst) (rd && (sel_rx_threshold || sel_tx_tl)) |=> rdata_q[DATA_W-1:TL_W] == '0;
  endproperty
  a_rd_thr: assert property (p_rd_thr) else $error("threshold upper bits not zero");

  property p_rd_clr;
    @(posedge clk) disable iff (rst) clr_rd |=> rdata_q == '0;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("clear register read not zero");

  property p_mask_gate;
    @(posedge clk) disable iff (rst) !mask_q[BIT_RXU] |=> !masked_status_q[BIT_RXU];
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked flag leaked");

  property p_rd_idle;
    @(posedge clk) disable iff (rst) !rd |=> rdata_q == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
endmodule

// ---- src/evt_stat_pkg.sv ----
// Purpose: constants for the fifo threshold and event status block
// Assumes: 16-bit registers on a plain byte-addressed port
// Notes:   offsets are the printed byte addresses
package evt_stat_pkg;
  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 16;
  localparam int          LVL_W           = 6;
  localparam int          FLAG_N          = 12;
  localparam logic [31:0] ADDR_STAT       = 32'h5000_1334;
  localparam logic [31:0] ADDR_RX_THRESHOLD      = 32'h5000_1338;
  localparam logic [31:0] ADDR_TX_TL      = 32'h5000_133C;
  localparam logic [31:0] ADDR_CLR_ALL    = 32'h5000_1340;
  localparam logic [31:0] ADDR_CLR_RXU    = 32'h5000_1344;
  localparam logic [31:0] ADDR_CLR_RXO    = 32'h5000_1348;
  localparam logic [31:0] ADDR_CLR_TXO    = 32'h5000_134C;
  localparam logic [31:0] ADDR_MASK       = 32'h5000_1330;
  localparam logic [31:0] ADDR_MSTAT      = 32'h5000_132C;
  localparam logic [31:0] ADDR_ABRT       = 32'h5000_1380;
  localparam logic [31:0] ADDR_ENABLE     = 32'h5000_136C;
  localparam int          BIT_RXU         = 0;
  localparam int          BIT_RXO         = 1;
  localparam int          BIT_RXF         = 2;
  localparam int          BIT_TXO         = 3;
  localparam int          BIT_TXE         = 4;
  localparam int          TL_W            = 5;
  localparam logic [4:0]  TL_RST          = 5'h00;
  localparam logic [11:0] MASK_RST        = 12'hFFF;
  localparam int          ABRT_KEEP_BIT   = 9;
  localparam int          FIFO_DEPTH      = 32;
endpackage

// ---- src/level_flags.sv ----
`timescale 1ns/1ps
// Purpose: level comparison flags for the fifo thresholds
// Assumes: levels and thresholds on the same clock
// Notes:   outputs are registered
module level_flags (
  // clock
  input  wire logic                           clk,
  input  wire logic                           rst,
  // levels
  input  wire logic [evt_stat_pkg::LVL_W-1:0] rx_level,
  input  wire logic [evt_stat_pkg::LVL_W-1:0] tx_level,
  input  wire logic [evt_stat_pkg::TL_W-1:0]  rx_thr,
  input  wire logic [evt_stat_pkg::TL_W-1:0]  tx_thr,
  input  wire logic                           rx_hold,
  input  wire logic                           tx_hold,
  // flags
  output logic                                rx_full_q,
  output logic                                tx_empty_q
);
  import evt_stat_pkg::*;
  wire [LVL_W-1:0] rx_trig = {1'b0, rx_thr} + LVL_W'(1);
  wire [LVL_W-1:0] tx_trig = {1'b0, tx_thr};
  wire             rx_d    = !rx_hold && (rx_level >= rx_trig);
  wire             tx_d    = !tx_hold && (tx_level <= tx_trig);
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_full_q  <= 1'b0;
      tx_empty_q <= 1'b0;
    end else begin
      rx_full_q  <= rx_d;
      tx_empty_q <= tx_d;
    end
  end
endmodule

// ---- verif/i2c_dev_model.sv ----
`timescale 1ns/1ps
// Purpose: far-side device that hands received bytes to the block
// Assumes: one byte per rising edge of send
// Notes:   counts acknowledges and stores seen from the block
module i2c_dev_model (
  // clock
  input  wire logic clk,
  input  wire logic rst,
  // control from bench
  input  wire logic send,
  // block side
  input  wire logic ack,
  input  wire logic store,
  output logic      byte_in,
  output int        acks,
  output int        stores
);
  logic send_q;
  always_ff @(posedge clk) begin
    send_q  <= send;
    byte_in <= send & ~send_q & ~rst;
    if (rst) begin
      acks   <= 0;
      stores <= 0;
    end else begin
      acks   <= acks + int'(ack);
      stores <= stores + int'(store);
    end
  end
endmodule

// ---- verif/i2c_fifo_event_status_tb_top.sv ----
`timescale 1ns/1ps
// Purpose: register-level tests of the event flags and thresholds
// Assumes: flags land one cycle after their cause, level flags also one
// Notes:   single clock, no random stimulus
module i2c_fifo_event_status_tb_top;
  import evt_stat_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, send = 0, idle = 0;
  logic [31:0] addr = 0;
  logic [15:0] wdata = 0, acause = 0, d, rdata_q;
  logic [5:0]  rxl = 0, txl = 1;
  logic [2:0]  ev = 0;
  logic [11:0] mst;
  logic        en, ien, flush, ack, store, rxb;
  int          acks, stores, err_count = 0, cmp_count = 0, cyc = 0;
  always #25 clk = ~clk;
  evt_stat uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .rx_level(rxl), .tx_level(txl), .cmd_write(ev[0]),
    .data_read(ev[1]), .rx_byte_in(rxb), .engines_idle(idle), .abort_event(ev[2]),
    .abort_cause_in(acause), .enable_q(en), .internal_enable_state_q(ien),
    .rx_flush_q(flush), .rx_ack_q(ack), .rx_store_q(store), .masked_status_q(mst));
  i2c_dev_model dev (.clk(clk), .rst(rst), .send(send), .ack(ack), .store(store),
    .byte_in(rxb), .acks(acks), .stores(stores));
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, the whole run needs under two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      $display("ERROR t=%0t timeout", $time);
      results();
    end
  end
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t reg got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t bit got %b exp %b", $time, g, e);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [31:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata_q;
    // back onto a rising edge so callers drive inputs there
    @(posedge clk);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd_reg(a, v);
    chk_reg(v, e);
  endtask
  task automatic sbit(input int b, input logic e);
    logic [15:0] v;
    rd_reg(ADDR_STAT, v);
    chk_bit(v[b], e);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1;
    @(posedge clk);
    ev[i] <= 0;
  endtask
  initial begin
    wait_n(8);
    rst <= 0;
    rchk(ADDR_RX_THRESHOLD, 16'h0000);
    rchk(ADDR_TX_TL, 16'h0000);
    rchk(ADDR_MASK, 16'h0FFF);
    rchk(ADDR_STAT, 16'h0000);
    chk_bit(flush, 1'b1);
    rchk(32'h5000_1000, 16'h0000);
    $display("test reset done");
    wr_reg(ADDR_ENABLE, 16'h0001);
    wait_n(2);
    chk_bit(ien, 1'b1);
    chk_bit(en, 1'b1);
    chk_bit(flush, 1'b0);
    pulse(1);
    sbit(0, 1'b1);
    chk_bit(mst[0], 1'b1);
    wr_reg(ADDR_MASK, 16'h0000);
    wait_n(2);
    chk_bit(mst[0], 1'b0);
    wr_reg(ADDR_MASK, 16'h0FFF);
    rd_reg(ADDR_CLR_RXU, d);
    chk_reg(d & 16'hFFFE, 16'h0000);
    sbit(0, 1'b0);
    $display("test underflow done");
    rxl <= 6'd32; send <= 1;
    wait_n(3);
    send <= 0;
    sbit(1, 1'b1);
    chk_bit(acks == 1 && stores == 0, 1'b1);
    rd_reg(ADDR_CLR_RXO, d);
    sbit(1, 1'b0);
    rxl <= 6'd31; send <= 1;
    wait_n(3);
    send <= 0;
    sbit(1, 1'b0);
    chk_bit(acks == 2 && stores == 1, 1'b1);
    $display("test overflow done");
    txl <= 6'd31;
    pulse(0);
    sbit(3, 1'b0);
    txl <= 6'd32;
    pulse(0);
    sbit(3, 1'b1);
    rxl <= 6'd0; acause <= 16'hFFFF;
    pulse(1);
    pulse(2);
    rchk(ADDR_ABRT, 16'hFFFF);
    rd_reg(ADDR_CLR_ALL, d);
    rchk(ADDR_STAT, 16'h0000);
    rchk(ADDR_ABRT, 16'h0200);
    pulse(0);
    sbit(3, 1'b1);
    rd_reg(ADDR_CLR_TXO, d);
    sbit(3, 1'b0);
    $display("test clear all done");
    wr_reg(ADDR_RX_THRESHOLD, 16'h0025);
    rchk(ADDR_RX_THRESHOLD, 16'h001F);
    wr_reg(ADDR_TX_TL, 16'h0030);
    rchk(ADDR_TX_TL, 16'h001F);
    wr_reg(ADDR_RX_THRESHOLD, 16'h0003);
    rxl <= 6'd3;
    wait_n(3);
    sbit(2, 1'b0);
    rxl <= 6'd4;
    wait_n(3);
    sbit(2, 1'b1);
    wr_reg(ADDR_TX_TL, 16'h0005);
    txl <= 6'd5;
    wait_n(3);
    sbit(4, 1'b1);
    txl <= 6'd6;
    wait_n(3);
    sbit(4, 1'b0);
    $display("test thresholds done");
    rxl <= 6'd0;
    pulse(1);
    rxl <= 6'd4;
    wait_n(3);
    wr_reg(ADDR_ENABLE, 16'h0000);
    sbit(2, 1'b0);
    chk_bit(flush, 1'b1);
    chk_bit(en, 1'b0);
    sbit(0, 1'b1);
    idle <= 1;
    wait_n(3);
    sbit(0, 1'b0);
    chk_bit(ien, 1'b0);
    $display("test disable done");
    results();
  end
endmodule
